// file: testbench/mbs_master_model.sv
/*
  Far-side model of the serial slave: a master that sends request bytes and
  drains answer bytes, stalling one cycle in four.
  Assumes the slave samples rx_valid and tx_ready on the rising edge of clk.
*/
`default_nettype none
module mbs_master_model (
  // Clock
  input wire logic clk,
  // Request bytes towards the slave
  output logic [7:0] rx_data,
  output logic rx_valid,
  // Answer bytes from the slave
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    phase = 2'h0;
  end

  // Sink pauses now and then
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    tx_ready <= tx_valid && (phase != 2'h3);
  end

  // Bytes back to back, then the line goes idle with a changed value
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clk);
      rx_data <= q[i];
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~q[q.size() - 1];
  endtask
endmodule
`default_nettype wire

// file: testbench/mbs_slave_tb.sv
/*
  Self-checking bench of the serial register-access slave.
  Assumes the slave and the master model compile alongside; short silence.
*/
`default_nettype none
module mbs_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 20;
  localparam logic [7:0] XFN[5] = '{8'h05, 8'h03, 8'h03, 8'h10, 8'h06};
  localparam logic [15:0] XREG[5] = '{16'h2401, 16'h2403, 16'h2401, 16'h2401, 16'h2403};
  localparam logic [15:0] XCNT[5] = '{16'h0001, 16'h0001, 16'h0015, 16'h0015, 16'h0001};
  localparam logic [7:0] XCODE[5] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h02};
  logic clk;
  logic nrst;
  logic [7:0] station;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic run_cmd;
  logic reverse_cmd;
  logic external_fault_from_link;
  logic fault_reset_cmd;
  logic [7:0] virtual_mfi;
  logic [15:0] freq_cmd;
  logic [7:0] warn;
  logic warn_valid;
  logic [7:0] frm[$];
  logic [7:0] rsp[$];
  logic [7:0] exp_q[$];
  int n_mismatch;
  int n_compared;
  int cycles;
  int seed;
  logic [15:0] v;
  logic [15:0] f;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  mbs_slave #(.SILENCE_CYC(S)) u_mbs_slave (
    .clk(clk), .nrst(nrst), .station_addr(station),
    .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .run_cmd(run_cmd), .reverse_cmd(reverse_cmd),
    .external_fault_from_link(external_fault_from_link),
    .fault_reset_cmd(fault_reset_cmd), .virtual_mfi(virtual_mfi), .freq_cmd(freq_cmd),
    .link_error_warning_display(warn), .link_error_warning_valid(warn_valid)
  );

  mbs_master_model u_mbs_master_model (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic b16(ref logic [7:0] q[$], input logic [15:0] w);
    q.push_back(w[15:8]);
    q.push_back(w[7:0]);
  endtask

  task automatic req(input logic [7:0] st, input logic [7:0] fn, input logic [15:0] a,
                     input logic [15:0] n);
    frm = {st, fn};
    b16(frm, a);
    b16(frm, n);
  endtask

  // Append check bytes, note the answer, send, wait for the answer to drain
  task automatic go(input bit bad);
    logic [15:0] c;
    c = crc16(frm) ^ {15'h0000, bad};
    frm.push_back(c[7:0]);
    frm.push_back(c[15:8]);
    if (rsp.size() > 0) begin
      c = crc16(rsp);
      rsp.push_back(c[7:0]);
      rsp.push_back(c[15:8]);
      exp_q = {exp_q, rsp};
    end
    u_mbs_master_model.send(frm);
    repeat (S + 3) @(posedge clk);
    for (int i = 0; i < 200 && tx_valid === 1'b1; i++) @(posedge clk);
    chk("answer bytes left", 16'h0000, 16'(exp_q.size()));
    rsp.delete();
    @(posedge clk);
  endtask

  // Answer watcher
  always @(posedge clk) begin
    if (nrst === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_compared++;
        n_mismatch++;
        $display("[ERR] tx_data expected none seen %h", tx_data);
      end else begin
        chk("tx_data", {8'h00, exp_q.pop_front()}, {8'h00, tx_data});
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[ERR] run length expected done seen running");
      wrap_up();
    end
  end

  initial begin
    seed = 40811;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    station = 8'h01;
    nrst = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("freq_cmd", 16'h0000, freq_cmd);
    chk("flags", 16'h0000, {2'h0, tx_valid, run_cmd, reverse_cmd, external_fault_from_link,
        fault_reset_cmd, warn_valid, virtual_mfi});
    v = 16'($random(seed)) & 16'hff0f;
    f = 16'($random(seed));
    req(8'h01, 8'h06, 16'h2401, v);
    rsp = frm;
    go(1'b0);
    chk("op word", v, {virtual_mfi, 4'h0, fault_reset_cmd, external_fault_from_link,
        reverse_cmd, run_cmd});
    req(8'h01, 8'h06, 16'h2402, f);
    rsp = frm;
    go(1'b0);
    chk("freq_cmd", f, freq_cmd);
    req(8'h01, 8'h03, 16'h2400, 16'h0003);
    rsp = {8'h01, 8'h03, 8'h06, 8'h00, 8'h00};
    b16(rsp, v);
    b16(rsp, f);
    go(1'b0);
    // Reserved word takes a write and still reads zero
    req(8'h01, 8'h06, 16'h2400, f);
    rsp = frm;
    go(1'b0);
    req(8'h01, 8'h03, 16'h2400, 16'h0001);
    rsp = {8'h01, 8'h03, 8'h02, 8'h00, 8'h00};
    go(1'b0);
    v = 16'($random(seed)) & 16'hff0f;
    f = 16'($random(seed));
    req(8'h01, 8'h10, 16'h2401, 16'h0002);
    frm.push_back(8'h04);
    b16(frm, v);
    b16(frm, f);
    rsp = frm[0:5];
    go(1'b0);
    chk("op word", v, {virtual_mfi, 4'h0, fault_reset_cmd, external_fault_from_link,
        reverse_cmd, run_cmd});
    chk("freq_cmd", f, freq_cmd);
    req(8'h01, 8'h06, 16'h2402, ~f);
    go(1'b1);
    chk("freq_cmd", f, freq_cmd);
    req(8'h02, 8'h06, 16'h2402, ~f);
    go(1'b0);
    chk("freq_cmd", f, freq_cmd);
    f = 16'($random(seed));
    req(8'h00, 8'h06, 16'h2402, f);
    go(1'b0);
    chk("freq_cmd", f, freq_cmd);
    // Station number zero switches the slave off
    station <= 8'h00;
    req(8'h01, 8'h06, 16'h2402, ~f);
    go(1'b0);
    chk("freq_cmd", f, freq_cmd);
    station <= 8'h01;
    for (int i = 0; i < 5; i++) begin
      req(8'h01, XFN[i], XREG[i], XCNT[i]);
      rsp = {8'h01, XFN[i] | 8'h80, XCODE[i]};
      go(1'b0);
      chk("warning", {8'h00, XCODE[i]}, {8'h00, warn});
      chk("warning valid", 16'h0001, {15'h0000, warn_valid});
    end
    // Loopback is silent and leaves the warning alone
    req(8'h01, 8'h08, 16'h0000, ~f);
    go(1'b0);
    chk("freq_cmd", f, freq_cmd);
    chk("warning", {8'h00, XCODE[4]}, {8'h00, warn});
    wrap_up();
  end
endmodule
`default_nettype wire

// file: verilog/mbs_consts.svh
/*
  Constants of the serial register-access slave: function codes, exception
  codes, register numbers, command bit positions, CRC and timing figures.
  Assumes it is included by bare name from the package or the modules.
*/
`ifndef MBS_CONSTS_SVH
`define MBS_CONSTS_SVH

`define MBS_FN_READ 8'h03
`define MBS_FN_WRITE1 8'h06
`define MBS_FN_LOOP 8'h08
`define MBS_FN_WRITEN 8'h10
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_NONE 8'h00
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_DATA 8'h03
`define MBS_BCAST 8'h00

`define MBS_REG_RSVD 16'h2400
`define MBS_REG_OPCMD 16'h2401
`define MBS_REG_FREQ 16'h2402
`define MBS_REG_END 17'h02403
`define MBS_MAX_WORDS 16'h0014
`define MBS_OPCMD_RESET 16'h0000
`define MBS_FREQ_RESET 16'h0000

`define MBS_OP_RUN 0
`define MBS_OP_REV 1
`define MBS_OP_EXTF 2
`define MBS_OP_FRST 3
`define MBS_OP_VMFI_LSB 8

`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001

`define MBS_LEN_FIX 8'h08
`define MBS_LEN_MIN 8'h04
`define MBS_LEN_EXC 8'h05
`define MBS_WN_HDR 8'h09
`define MBS_WN_DATA0 8'h07
`define MBS_RD_DATA0 8'h03

`define MBS_SILENCE_MS 10
`define MBS_CLK_KHZ 250000
`define MBS_SILENCE_CYC (`MBS_SILENCE_MS * `MBS_CLK_KHZ)

`endif

// file: verilog/mbs_crc.sv
/*
  Byte-wide reflected CRC-16 accumulator, one byte per strobe.
  Assumes clr and en come from the clk domain; clr wins over en.
*/
`default_nettype none
`include "mbs_consts.svh"
module mbs_crc (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte stream in, CRC out
  mbs_crc_if.unit port
);
  import mbs_pkg::*;

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // Eight shift steps with the reflected polynomial
  always_comb begin
    crc_next = crc_reg ^ {8'h00, port.data};
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ `MBS_CRC_POLY) : (crc_next >> 1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_reg <= `MBS_CRC_INIT;
    end else if (port.clr) begin
      crc_reg <= `MBS_CRC_INIT;
    end else if (port.en) begin
      crc_reg <= crc_next;
    end
  end

  assign port.crc = crc_reg;
endmodule
`default_nettype wire

// file: verilog/mbs_crc_if.sv
/*
  Carrier between the slave and a CRC unit: clear, byte strobe, byte, CRC.
  Assumes both ends share one clock.
*/
`default_nettype none
interface mbs_crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport user(output clr, output en, output data, input crc);
  modport unit(input clr, input en, input data, output crc);
endinterface
`default_nettype wire

// file: verilog/mbs_pkg.sv
/*
  Types of the serial register-access slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package mbs_pkg;
  typedef enum logic {mbs_st_rx, mbs_st_tx} mbs_state_t;
  typedef enum logic [1:0] {mbs_rsp_read, mbs_rsp_echo, mbs_rsp_ack, mbs_rsp_exc} mbs_resp_t;
endpackage
`default_nettype wire

// file: verilog/mbs_slave.sv
/*
  Serial register-access slave: parses request frames byte by byte, checks
  CRC and framing silence, executes reads and writes of the command group,
  and streams the normal or exception answer.
  Assumes bytes arrive already deframed from the UART, one per rx_valid,
  and that the sender drains tx_data under the valid/ready handshake.
*/
//
// Contract
// - Read returns byte count then words high-first
// - Single write stores value, echoes request
// - Multi write up to 20 words, short ack
// - Exception answer sets function bit 7
// - Exception code latched onto warning display
// - Operation word bits drive run, reverse, faults, inputs
// - Word at FREQUENCY_COMMAND_WORD is frequency command
// - Command words read/write; RESERVED_COMMAND_WORD reserved
// - CRC-16 A001h, low byte first, bad dropped
// - Ten millisecond silence delimits every frame
// - Broadcast executes but never answers
`default_nettype none
`include "mbs_consts.svh"
module mbs_slave #(
  parameter int unsigned SILENCE_CYC = `MBS_SILENCE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Station setting
  input wire logic [7:0] station_addr,
  // Received bytes
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  // Bytes to send
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Drive commands
  output logic run_cmd,
  output logic reverse_cmd,
  output logic external_fault_from_link,
  output logic fault_reset_cmd,
  output logic [7:0] virtual_mfi,
  output logic [15:0] freq_cmd,
  // Operator warning
  output logic [7:0] link_error_warning_display,
  output logic link_error_warning_valid
);
  import mbs_pkg::*;

  mbs_state_t st_reg;
  mbs_resp_t kind_reg;
  logic [21:0] sil_reg;
  logic [7:0] rx_idx_reg, rx_addr_reg, rx_func_reg, rx_bcnt_reg, rx_hi_reg;
  logic [15:0] rx_start_reg, rx_arg_reg;
  logic [15:0] op_reg, freq_reg, stg_op_reg, stg_freq_reg;
  logic stg_op_we_reg, stg_freq_we_reg;
  logic [7:0] exc_reg, tx_idx_reg, tx_len_reg, tx_data_reg;
  logic [7:0] warn_reg;
  logic warn_valid_reg;

  mbs_crc_if rx_crc ();
  mbs_crc_if tx_crc ();
  mbs_crc u_rx_crc (.clk(clk), .nrst(nrst), .port(rx_crc));
  mbs_crc u_tx_crc (.clk(clk), .nrst(nrst), .port(tx_crc));

  // Receive side decode
  wire rx_take = (st_reg == mbs_st_rx) && rx_valid;
  wire eval = (st_reg == mbs_st_rx) && !rx_valid && (rx_idx_reg != 8'h00) &&
              (sil_reg == 22'(SILENCE_CYC - 1));
  wire crc_ok = (rx_crc.crc == 16'h0000) && (rx_idx_reg >= `MBS_LEN_MIN);
  wire bcast = (rx_addr_reg == `MBS_BCAST);
  wire addr_hit = (station_addr != `MBS_BCAST) && (bcast || rx_addr_reg == station_addr);
  wire fn_rd = (rx_func_reg == `MBS_FN_READ);
  wire fn_w1 = (rx_func_reg == `MBS_FN_WRITE1);
  wire fn_wn = (rx_func_reg == `MBS_FN_WRITEN);
  wire fn_lp = (rx_func_reg == `MBS_FN_LOOP);
  wire cnt_ok = (rx_arg_reg != 16'h0000) && (rx_arg_reg <= `MBS_MAX_WORDS);
  wire [7:0] cnt_bytes = {rx_arg_reg[6:0], 1'b0};
  wire start_in = (rx_start_reg >= `MBS_REG_RSVD) && (rx_start_reg <= `MBS_REG_FREQ);
  wire range_ok = start_in && (({1'b0, rx_start_reg} + {1'b0, rx_arg_reg}) <= `MBS_REG_END);
  wire fix_len = (rx_idx_reg == `MBS_LEN_FIX);
  wire wn_len = (rx_bcnt_reg == cnt_bytes) && (rx_idx_reg == `MBS_WN_HDR + rx_bcnt_reg);
  wire [7:0] exc_code =
    (!fn_rd && !fn_w1 && !fn_wn && !fn_lp) ? `MBS_EXC_FUNC :
    (fn_rd && (!fix_len || !cnt_ok)) ? `MBS_EXC_DATA :
    (fn_rd && !range_ok) ? `MBS_EXC_ADDR :
    (fn_w1 && !fix_len) ? `MBS_EXC_DATA :
    (fn_w1 && !start_in) ? `MBS_EXC_ADDR :
    (fn_wn && (!cnt_ok || !wn_len)) ? `MBS_EXC_DATA :
    (fn_wn && !range_ok) ? `MBS_EXC_ADDR : `MBS_EXC_NONE;
  wire accept = eval && crc_ok && addr_hit;
  wire do_write = accept && (exc_code == `MBS_EXC_NONE) && (fn_w1 || fn_wn);
  wire respond = accept && !bcast && !fn_lp;
  wire is_exc = (exc_code != `MBS_EXC_NONE);
  wire [7:0] rsp_len = is_exc ? `MBS_LEN_EXC :
                       fn_rd ? 8'(`MBS_LEN_EXC + cnt_bytes) : `MBS_LEN_FIX;

  // Multi-write data words land in staging until the CRC is known
  wire [7:0] wn_pos = rx_idx_reg - `MBS_WN_DATA0;
  wire wn_byte = rx_take && fn_wn && (rx_idx_reg >= `MBS_WN_DATA0) && (wn_pos < cnt_bytes);
  wire [15:0] wn_reg = rx_start_reg + {9'h000, wn_pos[7:1]};
  wire wn_word = wn_byte && wn_pos[0];

  assign rx_crc.clr = eval;
  assign rx_crc.en = rx_take;
  assign rx_crc.data = rx_data;

  // Transmit side byte selection for the next index
  wire [7:0] nxt_i = tx_idx_reg + 8'h01;
  wire [7:0] rd_pos = nxt_i - `MBS_RD_DATA0;
  wire [15:0] rd_reg = rx_start_reg + {9'h000, rd_pos[7:1]};
  wire [15:0] rd_word = (rd_reg == `MBS_REG_OPCMD) ? op_reg :
                        (rd_reg == `MBS_REG_FREQ) ? freq_reg : 16'h0000;
  wire [15:0] echo_word = rx_arg_reg;
  wire [7:0] body_byte =
    (kind_reg == mbs_rsp_exc) ? exc_reg :
    (kind_reg == mbs_rsp_read) ? ((nxt_i == 8'h02) ? cnt_bytes :
                                  (rd_pos[0] ? rd_word[7:0] : rd_word[15:8])) :
    (nxt_i == 8'h02) ? rx_start_reg[15:8] :
    (nxt_i == 8'h03) ? rx_start_reg[7:0] :
    (nxt_i == 8'h04) ? echo_word[15:8] : echo_word[7:0];
  wire [7:0] func_byte = (kind_reg == mbs_rsp_exc) ? (rx_func_reg | `MBS_EXC_FLAG) :
                         rx_func_reg;
  wire [7:0] load_byte =
    eval ? rx_addr_reg :
    (nxt_i == 8'h01) ? func_byte :
    (nxt_i == tx_len_reg - 8'h02) ? tx_crc.crc[7:0] :
    (nxt_i == tx_len_reg - 8'h01) ? tx_crc.crc[15:8] : body_byte;
  wire tx_fire = (st_reg == mbs_st_tx) && tx_ready;
  wire tx_last = tx_fire && (tx_idx_reg == tx_len_reg - 8'h01);

  assign tx_crc.clr = tx_last;
  assign tx_crc.en = respond || (tx_fire && !tx_last && (nxt_i < tx_len_reg - 8'h02));
  assign tx_crc.data = load_byte;

  // Frame silence timer and state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sil_reg <= 22'h000000;
    end else begin
      sil_reg <= (rx_take || eval || st_reg == mbs_st_tx) ? 22'h000000 : sil_reg + 22'h000001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= mbs_st_rx;
    end else if (respond) begin
      st_reg <= mbs_st_tx;
    end else if (tx_last) begin
      st_reg <= mbs_st_rx;
    end
  end

  // Header field capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_idx_reg <= 8'h00;
    end else if (eval) begin
      rx_idx_reg <= 8'h00;
    end else if (rx_take && rx_idx_reg != 8'hff) begin
      rx_idx_reg <= rx_idx_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_addr_reg <= 8'h00;
      rx_func_reg <= 8'h00;
      rx_start_reg <= 16'h0000;
      rx_arg_reg <= 16'h0000;
      rx_bcnt_reg <= 8'h00;
      rx_hi_reg <= 8'h00;
    end else if (rx_take) begin
      if (rx_idx_reg == 8'h00) rx_addr_reg <= rx_data;
      if (rx_idx_reg == 8'h01) rx_func_reg <= rx_data;
      if (rx_idx_reg == 8'h02) rx_start_reg[15:8] <= rx_data;
      if (rx_idx_reg == 8'h03) rx_start_reg[7:0] <= rx_data;
      if (rx_idx_reg == 8'h04) rx_arg_reg[15:8] <= rx_data;
      if (rx_idx_reg == 8'h05) rx_arg_reg[7:0] <= rx_data;
      if (rx_idx_reg == 8'h06) rx_bcnt_reg <= rx_data;
      rx_hi_reg <= rx_data;
    end
  end

  // Staging of multi-write words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stg_op_reg <= `MBS_OPCMD_RESET;
      stg_freq_reg <= `MBS_FREQ_RESET;
      stg_op_we_reg <= 1'b0;
      stg_freq_we_reg <= 1'b0;
    end else if (eval) begin
      stg_op_we_reg <= 1'b0;
      stg_freq_we_reg <= 1'b0;
    end else if (wn_word) begin
      if (wn_reg == `MBS_REG_OPCMD) stg_op_reg <= {rx_hi_reg, rx_data};
      if (wn_reg == `MBS_REG_OPCMD) stg_op_we_reg <= 1'b1;
      if (wn_reg == `MBS_REG_FREQ) stg_freq_reg <= {rx_hi_reg, rx_data};
      if (wn_reg == `MBS_REG_FREQ) stg_freq_we_reg <= 1'b1;
    end
  end

  // Command registers, committed only by a good frame
  wire w1_op = do_write && fn_w1 && (rx_start_reg == `MBS_REG_OPCMD);
  wire w1_freq = do_write && fn_w1 && (rx_start_reg == `MBS_REG_FREQ);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_reg <= `MBS_OPCMD_RESET;
      freq_reg <= `MBS_FREQ_RESET;
    end else begin
      if (w1_op) op_reg <= rx_arg_reg;
      if (do_write && fn_wn && stg_op_we_reg) op_reg <= stg_op_reg;
      if (w1_freq) freq_reg <= rx_arg_reg;
      if (do_write && fn_wn && stg_freq_we_reg) freq_reg <= stg_freq_reg;
    end
  end

  // Answer setup and byte stream
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind_reg <= mbs_rsp_read;
      exc_reg <= `MBS_EXC_NONE;
      tx_len_reg <= `MBS_LEN_EXC;
    end else if (respond) begin
      kind_reg <= is_exc ? mbs_rsp_exc : fn_rd ? mbs_rsp_read :
                  fn_w1 ? mbs_rsp_echo : mbs_rsp_ack;
      exc_reg <= exc_code;
      tx_len_reg <= rsp_len;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_idx_reg <= 8'h00;
      tx_data_reg <= 8'h00;
    end else if (respond) begin
      tx_idx_reg <= 8'h00;
      tx_data_reg <= load_byte;
    end else if (tx_fire && !tx_last) begin
      tx_idx_reg <= nxt_i;
      tx_data_reg <= load_byte;
    end
  end

  // Warning latch, replaced by each new exception answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn_reg <= `MBS_EXC_NONE;
      warn_valid_reg <= 1'b0;
    end else if (respond && is_exc) begin
      warn_reg <= exc_code;
      warn_valid_reg <= 1'b1;
    end
  end

  assign tx_data = tx_data_reg;
  assign tx_valid = (st_reg == mbs_st_tx);
  assign run_cmd = op_reg[`MBS_OP_RUN];
  assign reverse_cmd = op_reg[`MBS_OP_REV];
  assign external_fault_from_link = op_reg[`MBS_OP_EXTF];
  assign fault_reset_cmd = op_reg[`MBS_OP_FRST];
  assign virtual_mfi = op_reg[`MBS_OP_VMFI_LSB +: 8];
  assign freq_cmd = freq_reg;
  assign link_error_warning_display = warn_reg;
  assign link_error_warning_valid = warn_valid_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_read_bytecount: assert property (
    (tx_fire && kind_reg == mbs_rsp_read && tx_idx_reg == 8'h01)
      |=> tx_data == {rx_arg_reg[6:0], 1'b0})
    else $error("read byte count wrong");
  chk_echo_value: assert property (
    (tx_fire && kind_reg == mbs_rsp_echo && tx_idx_reg == 8'h03)
      |=> tx_data == rx_arg_reg[15:8])
    else $error("single write echo wrong");
  chk_ack_length: assert property (
    (respond && fn_wn && !is_exc) |=> tx_len_reg == 8'h08)
    else $error("multi write ack length wrong");
  chk_exc_func_bit: assert property (
    (tx_fire && kind_reg == mbs_rsp_exc && tx_idx_reg == 8'h00) |=> tx_data[7])
    else $error("exception function bit clear");
  chk_warn_latch: assert property (
    (respond && is_exc) |=> link_error_warning_valid &&
      link_error_warning_display == $past(exc_code))
    else $error("warning code not latched");
  chk_run_bit: assert property (
    w1_op |=> run_cmd == $past(rx_arg_reg[0]) && virtual_mfi == $past(rx_arg_reg[15:8]))
    else $error("operation word not decoded");
  chk_freq_write: assert property (
    w1_freq |=> freq_cmd == $past(rx_arg_reg))
    else $error("frequency word not stored");
  chk_rsvd_read: assert property (
    (tx_fire && kind_reg == mbs_rsp_read && nxt_i >= 8'h03 &&
     nxt_i < tx_len_reg - 8'h02 && rd_reg == `MBS_REG_RSVD) |=> tx_data == 8'h00)
    else $error("reserved register not zero");
  chk_bad_crc_drop: assert property (
    (eval && !crc_ok) |=> st_reg == mbs_st_rx && $stable(op_reg) && $stable(freq_reg))
    else $error("bad CRC frame acted on");
  chk_silence_end: assert property (
    rx_take |=> !eval)
    else $error("frame ended without silence");
  chk_bcast_quiet: assert property (
    (eval && bcast) |=> st_reg == mbs_st_rx)
    else $error("broadcast answered");
  chk_bad_func_exc: assert property (
    (respond && !fn_rd && !fn_w1 && !fn_wn) |=>
      kind_reg == mbs_rsp_exc && exc_reg == `MBS_EXC_FUNC)
    else $error("unknown function not refused");

  cov_read: cover property (respond && fn_rd && !is_exc);
  cov_write1: cover property (w1_freq);
  cov_exc: cover property (respond && is_exc);
  cov_bcast_write: cover property (do_write && bcast);
endmodule
`default_nettype wire
